//--- verilog/rtcp_mst.sv
`timescale 1ns/1ps
`include "rtcp_cfg.svh"
// bus master: one command moves len bytes, with optional pointer byte
module rtcp_mst
  import rtcp_pkg::*;
#(
  parameter logic [7:0] QTR = `RTCP_QTR_TICKS
)(
  input wire logic core_clk, // core clock
  input wire logic rst, // synchronous reset
  rtcp_bus_if.mst bus, // serial bus
  input wire logic cmd_valid, // start a transaction
  output logic cmd_ready, // idle, accepts command
  input wire logic cmd_read, // 1 read, 0 write
  input wire logic cmd_use_ptr, // send pointer byte first
  input wire logic [7:0] cmd_ptr, // pointer value
  input wire logic [7:0] cmd_len, // data bytes, at least one
  input wire logic [7:0] wdata, // next write byte
  output logic wdata_take, // pulse: wdata consumed
  output logic [7:0] rdata, // last data byte sampled, read or write
  output logic rdata_valid, // pulse: rdata new
  output logic nack_err // level: device did not acknowledge
);
  // a zero quarter would wrap QTR - 1 to 255 and tick only once per 256 cycles
  if (QTR == 8'h00) begin : g_qtr_chk
    $error("QTR must be nonzero");
  end
  rtcp_mst_e st_r, st_nxt;
  logic [7:0] div_r, div_nxt, sh_r, sh_nxt, len_r, len_nxt, rd_r, rd_nxt;
  logic [1:0] ph_r, ph_nxt, sda_sy_r;
  logic [3:0] bit_r, bit_nxt;
  logic [2:0] by_r, by_nxt;
  logic scl_r, scl_nxt, sda_r, sda_nxt, rd_m_r, rd_m_nxt, up_r, up_nxt;
  logic rv_r, rv_nxt, err_r, err_nxt, tk_r, tk_nxt, tick;
  logic [7:0] ab;

  assign tick = (div_r == QTR - 8'h01);
  // byte sequence: by 0 addr, 1 pointer, 2 data
  always_comb begin
    st_nxt = st_r;
    div_nxt = tick ? 8'h00 : div_r + 8'h01;
    ph_nxt = ph_r;
    sh_nxt = sh_r;
    len_nxt = len_r;
    rd_nxt = rd_r;
    bit_nxt = bit_r;
    by_nxt = by_r;
    scl_nxt = scl_r;
    sda_nxt = sda_r;
    rd_m_nxt = rd_m_r;
    up_nxt = up_r;
    err_nxt = err_r;
    rv_nxt = 1'b0;
    tk_nxt = 1'b0;
    ab = {`RTCP_DEV_ADDR, (cmd_read && !cmd_use_ptr) ? `RTCP_DIR_READ : `RTCP_DIR_WRITE};
    if (st_r == RTCP_M_IDLE && cmd_valid) begin
      st_nxt = RTCP_M_START;
      ph_nxt = 2'h0;
      rd_m_nxt = cmd_read;
      up_nxt = cmd_use_ptr;
      len_nxt = cmd_len;
      sh_nxt = ab;
      by_nxt = 3'h0;
      err_nxt = 1'b0;
      div_nxt = 8'h00;
    end else if (tick) begin
      ph_nxt = ph_r + 2'h1;
      unique case (st_r)
        RTCP_M_IDLE: ;
        RTCP_M_START, RTCP_M_RSTART: begin
          if (ph_r == 2'h0) begin
            sda_nxt = 1'b1;
          end else if (ph_r == 2'h1) begin
            scl_nxt = 1'b1;
          end else if (ph_r == 2'h2) begin
            sda_nxt = 1'b0;
          end else begin
            scl_nxt = 1'b0;
            bit_nxt = 4'h0;
            st_nxt = RTCP_M_BIT;
          end
        end
        RTCP_M_BIT: begin
          if (ph_r == 2'h0) begin
            sda_nxt = (by_r == 3'h2 && rd_m_r) ? 1'b1 : sh_r[7];
          end else if (ph_r == 2'h1) begin
            scl_nxt = 1'b1;
          end else if (ph_r == 2'h2) begin
            sh_nxt = {sh_r[6:0], sda_sy_r[1]};
          end else begin
            scl_nxt = 1'b0;
            bit_nxt = bit_r + 4'h1;
            if (bit_r == `RTCP_LAST_BIT) begin
              st_nxt = RTCP_M_ACK;
            end
          end
        end
        RTCP_M_ACK: begin
          if (ph_r == 2'h0) begin
            sda_nxt = !(by_r == 3'h2 && rd_m_r && len_r != 8'h01);
          end else if (ph_r == 2'h1) begin
            scl_nxt = 1'b1;
          end else if (ph_r == 2'h2) begin
            if (!(by_r == 3'h2 && rd_m_r) && sda_sy_r[1]) begin
              err_nxt = 1'b1;
            end
          end else begin
            scl_nxt = 1'b0;
            st_nxt = RTCP_M_NEXT;
            if (by_r == 3'h2) begin
              len_nxt = len_r - 8'h01;
              rd_nxt = sh_r;
              rv_nxt = rd_m_r;
              tk_nxt = !rd_m_r;
            end
          end
        end
        RTCP_M_NEXT: begin
          ph_nxt = 2'h0;
          sda_nxt = 1'b1;
          bit_nxt = 4'h0;
          st_nxt = RTCP_M_BIT;
          if (err_r || (by_r == 3'h2 && len_r == 8'h00)) begin
            st_nxt = RTCP_M_STOP;
          end else if (by_r == 3'h0 && up_r) begin
            by_nxt = 3'h1;
            sh_nxt = cmd_ptr;
          end else if (by_r == 3'h1 && rd_m_r) begin
            by_nxt = 3'h0;
            up_nxt = 1'b0;
            sh_nxt = {`RTCP_DEV_ADDR, `RTCP_DIR_READ};
            st_nxt = RTCP_M_RSTART;
          end else begin
            by_nxt = 3'h2;
            sh_nxt = rd_m_r ? 8'hff : wdata;
          end
        end
        RTCP_M_STOP: begin
          if (ph_r == 2'h0) begin
            sda_nxt = 1'b0;
          end else if (ph_r == 2'h1) begin
            scl_nxt = 1'b1;
          end else if (ph_r == 2'h2) begin
            sda_nxt = 1'b1;
          end else begin
            st_nxt = RTCP_M_IDLE;
          end
        end
        default: st_nxt = RTCP_M_IDLE;
      endcase
    end
  end

  // register the master state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= RTCP_M_IDLE;
      div_r <= 8'h00;
      ph_r <= 2'h0;
      sh_r <= 8'h00;
      len_r <= 8'h00;
      rd_r <= 8'h00;
      bit_r <= 4'h0;
      by_r <= 3'h0;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      rd_m_r <= 1'b0;
      up_r <= 1'b0;
      err_r <= 1'b0;
      rv_r <= 1'b0;
      tk_r <= 1'b0;
      sda_sy_r <= 2'h3;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      ph_r <= ph_nxt;
      sh_r <= sh_nxt;
      len_r <= len_nxt;
      rd_r <= rd_nxt;
      bit_r <= bit_nxt;
      by_r <= by_nxt;
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
      rd_m_r <= rd_m_nxt;
      up_r <= up_nxt;
      err_r <= err_nxt;
      rv_r <= rv_nxt;
      tk_r <= tk_nxt;
      sda_sy_r <= {sda_sy_r[0], bus.sda};
    end
  end

  // open-drain outputs: enable means pull low
  assign bus.scl_o_m = 1'b0;
  assign bus.scl_oe_m = !scl_r;
  assign bus.sda_o_m = 1'b0;
  assign bus.sda_oe_m = !sda_r;
  assign cmd_ready = (st_r == RTCP_M_IDLE);
  assign rdata = rd_r;
  assign rdata_valid = rv_r;
  assign wdata_take = tk_r;
  assign nack_err = err_r;
endmodule : rtcp_mst

//--- verilog/rtcp_cfg.svh
`ifndef RTCP_CFG_SVH
`define RTCP_CFG_SVH
// own bus address, seven bits
`define RTCP_DEV_ADDR 7'h68
// direction bit values
`define RTCP_DIR_READ 1'b1
`define RTCP_DIR_WRITE 1'b0
// bits in a byte and the index of the last data bit
`define RTCP_BYTE_BITS 4'h8
`define RTCP_LAST_BIT 4'h7
// register pointer reset value
`define RTCP_PTR_RST 8'h00
// ticks of the core clock per quarter of a serial clock period
`define RTCP_QTR_TICKS 8'h04
`endif

//--- verilog/rtcp_pkg.sv
package rtcp_pkg;
  typedef enum logic [2:0] {
    RTCP_S_IDLE,
    RTCP_S_ADDR,
    RTCP_S_ACK,
    RTCP_S_WPTR,
    RTCP_S_WDATA,
    RTCP_S_RDATA,
    RTCP_S_RACK,
    RTCP_S_WAIT
  } rtcp_dev_e;
  typedef enum logic [3:0] {
    RTCP_M_IDLE,
    RTCP_M_START,
    RTCP_M_BIT,
    RTCP_M_ACK,
    RTCP_M_NEXT,
    RTCP_M_RSTART,
    RTCP_M_STOP,
    RTCP_M_DONE
  } rtcp_mst_e;
  typedef logic [7:0] rtcp_byte_t;
endpackage : rtcp_pkg

//--- verilog/rtcp_bus_if.sv
`timescale 1ns/1ps
// two open-drain wires resolved as a wired and: low while either enable is set
interface rtcp_bus_if;
  logic scl_oe_m;
  logic scl_oe_s;
  logic sda_oe_m;
  logic sda_oe_s;
  logic scl_o_m;
  logic sda_o_m;
  logic scl_o_s;
  logic sda_o_s;
  logic scl;
  logic sda;
  assign scl = !((scl_oe_m && !scl_o_m) || (scl_oe_s && !scl_o_s));
  assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_s && !sda_o_s));
  modport dev (input scl, input sda, output scl_o_s, output scl_oe_s, output sda_o_s,
    output sda_oe_s);
  modport mst (input scl, input sda, output scl_o_m, output scl_oe_m, output sda_o_m,
    output sda_oe_m);
endinterface : rtcp_bus_if

//--- verilog/rtcp_dev.sv
`timescale 1ns/1ps
`include "rtcp_cfg.svh"
// What this block does
// - detect start: data falls, clock high
// - detect stop: data rises, clock high
// - start before stop restarts address reception
// - bytes of eight, no count limit
// - pointer increments after each data byte
// - drive data only while clock low
// - data change with clock high is condition
// - acknowledge low after each received byte
// - release/drive after eighth falling edge
// - release acknowledge at ninth falling edge
// - no master acknowledge: release, await stop
// - answer only own seven-bit address
// - bit zero direction, one read
// - first written byte loads pointer
// - host avoids test addresses 49h, 4ah
module rtcp_dev
  import rtcp_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic rst, // synchronous reset
  rtcp_bus_if.dev bus, // serial bus
  output logic [7:0] reg_addr, // register pointer
  output logic [7:0] wr_data, // written byte
  output logic wr_stb, // one-cycle write strobe
  input wire logic [7:0] rd_data, // byte at reg_addr
  output logic busy // transaction open: start seen, address own or not yet received
);
  rtcp_dev_e st_r, st_nxt;
  logic [1:0] scl_sy_r, sda_sy_r;
  logic scl_q_r, sda_q_r;
  logic [3:0] cnt_r, cnt_nxt;
  rtcp_byte_t sh_r, sh_nxt, ptr_r, ptr_nxt, wd_r, wd_nxt;
  logic dir_r, dir_nxt, oe_r, oe_nxt, stb_r, stb_nxt;
  // set while the coming ack slot belongs to an address byte
  logic adr_r, adr_nxt;
  logic scl_s, sda_s, rise, fall, start_c, stop_c;

  // two-flop synchronisers, then a history flop for edges
  // the history flop lets a condition demand two high clock samples
  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_sy_r <= {scl_sy_r[0], bus.scl};
      sda_sy_r <= {sda_sy_r[0], bus.sda};
      scl_q_r <= scl_sy_r[1];
      sda_q_r <= sda_sy_r[1];
    end
  end

  // edge and condition decode
  always_comb begin
    scl_s = scl_sy_r[1];
    sda_s = sda_sy_r[1];
    rise = scl_s && !scl_q_r;
    fall = !scl_s && scl_q_r;
    start_c = scl_s && scl_q_r && sda_q_r && !sda_s;
    stop_c = scl_s && scl_q_r && !sda_q_r && sda_s;
  end

  // transaction state
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    wd_nxt = wd_r;
    dir_nxt = dir_r;
    oe_nxt = oe_r;
    adr_nxt = adr_r;
    stb_nxt = 1'b0;
    // a condition outranks any bit handling, whatever the state
    if (stop_c) begin
      st_nxt = RTCP_S_IDLE;
      oe_nxt = 1'b0;
    end else if (start_c) begin
      st_nxt = RTCP_S_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else begin
      unique case (st_r)
        RTCP_S_IDLE, RTCP_S_WAIT: begin
          oe_nxt = 1'b0;
        end
        RTCP_S_ADDR, RTCP_S_WPTR, RTCP_S_WDATA: begin
          if (rise) begin
            sh_nxt = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end
          if (fall && cnt_r == `RTCP_BYTE_BITS) begin
            cnt_nxt = 4'h0;
            if (st_r == RTCP_S_ADDR) begin
              if (sh_r[7:1] == `RTCP_DEV_ADDR) begin
                dir_nxt = sh_r[0];
                oe_nxt = 1'b1;
                adr_nxt = 1'b1;
                st_nxt = RTCP_S_ACK;
              end else begin
                st_nxt = RTCP_S_WAIT;
              end
            end else begin
              oe_nxt = 1'b1;
              adr_nxt = 1'b0;
              if (st_r == RTCP_S_WPTR) begin
                ptr_nxt = sh_r;
              end else begin
                wd_nxt = sh_r;
                stb_nxt = 1'b1;
              end
              st_nxt = RTCP_S_ACK;
            end
          end
        end
        RTCP_S_ACK: begin
          // the slot ends at its falling edge; the byte before picks what follows
          if (fall) begin
            oe_nxt = 1'b0;
            if (dir_r == `RTCP_DIR_READ) begin
              sh_nxt = rd_data;
              oe_nxt = !rd_data[7];
              st_nxt = RTCP_S_RDATA;
            end else if (adr_r) begin
              st_nxt = RTCP_S_WPTR;
            end else begin
              st_nxt = RTCP_S_WDATA;
            end
          end
        end
        RTCP_S_RDATA: begin
          if (rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end
          if (fall) begin
            if (cnt_r == `RTCP_BYTE_BITS) begin
              oe_nxt = 1'b0;
              cnt_nxt = 4'h0;
              ptr_nxt = ptr_r + 8'h01;
              st_nxt = RTCP_S_RACK;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_nxt = !sh_r[6];
            end
          end
        end
        RTCP_S_RACK: begin
          // the master's bit here says: one more byte or wait for stop
          if (rise) begin
            sh_nxt[0] = sda_s;
          end
          if (fall) begin
            if (sh_r[0]) begin
              st_nxt = RTCP_S_WAIT;
            end else begin
              sh_nxt = rd_data;
              oe_nxt = !rd_data[7];
              st_nxt = RTCP_S_RDATA;
            end
          end
        end
      endcase
    end
    if (stb_r) begin
      ptr_nxt = ptr_r + 8'h01;
    end
  end

  // register the transaction state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= RTCP_S_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= `RTCP_PTR_RST;
      wd_r <= 8'h00;
      dir_r <= 1'b0;
      oe_r <= 1'b0;
      adr_r <= 1'b0;
      stb_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      wd_r <= wd_nxt;
      dir_r <= dir_nxt;
      oe_r <= oe_nxt;
      stb_r <= stb_nxt;
      adr_r <= adr_nxt;
    end
  end

  // open-drain drive; the clock line is never stretched
  assign bus.sda_o_s = 1'b0;
  assign bus.sda_oe_s = oe_r;
  assign bus.scl_o_s = 1'b0;
  assign bus.scl_oe_s = 1'b0;
  assign reg_addr = ptr_r;
  assign wr_data = wd_r;
  assign wr_stb = stb_r;
  // busy stays low while another target's transfer is ignored
  assign busy = (st_r != RTCP_S_IDLE) && (st_r != RTCP_S_WAIT);
endmodule : rtcp_dev

//--- verification/rtcp_props.sv
`timescale 1ns/1ps
// watches the wires between master and device
module rtcp_props (
  input wire logic core_clk, // core clock
  input wire logic rst, // sync reset
  input wire logic scl, // clock wire
  input wire logic sda, // data wire
  input wire logic sda_oe_s, // device pulls data
  input wire logic sda_oe_m // master pulls data
);
  logic scl_r, sda_r, rd_r, rd_nxt, go, stp, fall, rise;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] byte_r, byte_nxt;
  // conditions, bit slot, byte count and direction
  always_comb begin
    go = scl && scl_r && sda_r && !sda;
    stp = scl && scl_r && !sda_r && sda;
    fall = scl_r && !scl;
    rise = !scl_r && scl;
    bit_nxt = bit_r;
    byte_nxt = byte_r;
    rd_nxt = rd_r;
    if (go) begin
      bit_nxt = 4'hf;
      byte_nxt = 8'h00;
      rd_nxt = 1'h0;
    end else if (fall) begin
      bit_nxt = (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
      byte_nxt = byte_r + {7'h00, bit_r == 4'h8};
    end else if (rise && bit_r == 4'h7 && byte_r == 8'h00) begin
      rd_nxt = sda;
    end
  end
  // register the trackers, bus idle after reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {scl_r, sda_r, rd_r, bit_r, byte_r} <= {3'h6, 4'h0, 8'h00};
    end else begin
      {scl_r, sda_r, rd_r, bit_r, byte_r} <= {scl, sda, rd_nxt, bit_nxt, byte_nxt};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ack_give_a: assert property (rise && bit_r == 4'h8 && (!rd_r || byte_r == 8'h00)
    |-> sda_oe_s) else $error("device gave no acknowledge");
  ack_drop_a: assert property (fall && bit_r == 4'h8 && !rd_r
    |-> ##[1:6] !sda_oe_s) else $error("device kept acknowledge");
  rd_gap_a: assert property (rise && bit_r == 4'h8 && rd_r && byte_r != 8'h00
    |-> !sda_oe_s) else $error("device drove master ack slot");
  mst_quiet_a: assert property (fall && rd_r && byte_r != 8'h00 && bit_r < 4'h8
    |-> !sda_oe_m) else $error("master drove read data");
  nack_idle_a: assert property (rise && bit_r == 4'h8 && rd_r && byte_r != 8'h00 && sda
    |-> (!sda_oe_s) [*8]) else $error("device drove after nack");
  dev_hold_a: assert property (scl && scl_r |-> $stable(sda_oe_s))
    else $error("device changed data with clock high");
  mst_cond_a: assert property (scl && scl_r && $changed(sda_oe_m) |-> bit_r == 4'h0)
    else $error("master data change inside a byte");
  stop_free_a: assert property (stp |-> (!sda_oe_s) [*4])
    else $error("device drove after stop");
endmodule : rtcp_props

//--- verification/rtcp_i2c_slave_port_tb.sv
`timescale 1ns/1ps
module rtcp_i2c_slave_port_tb
  import rtcp_pkg::*;
;
  typedef struct {
    logic rd;
    logic up;
    rtcp_byte_t ptr;
    rtcp_byte_t len;
    rtcp_byte_t wb;
    rtcp_byte_t endp;
  } rtcp_row_s;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic cmd_valid = 1'h0;
  logic cmd_read = 1'h0;
  logic cmd_use_ptr = 1'h0;
  logic b_scl = 1'h0;
  logic b_sda = 1'h0;
  logic cmd_ready, wdata_take, rdata_valid, nack_err, wr_stb, busy, ack, busy_b;
  rtcp_byte_t cmd_ptr = 8'h00;
  rtcp_byte_t cmd_len = 8'h01;
  rtcp_byte_t wb = 8'h00;
  rtcp_byte_t wi = 8'h00;
  rtcp_byte_t cnt = 8'h00;
  rtcp_byte_t exp_p = 8'h00;
  rtcp_byte_t cur_p = 8'h00;
  rtcp_byte_t wdata, rdata, reg_addr, wr_data, rd_data, reg_addr_b;
  rtcp_byte_t mem [256];
  rtcp_byte_t exp_mem [256];
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  // rows: read, pointer byte, pointer, length, first byte, pointer after
  rtcp_row_s rows [7] = '{'{1'h0, 1'h1, 8'h10, 8'h03, 8'ha0, 8'h13},
    '{1'h1, 1'h1, 8'h10, 8'h03, 8'h00, 8'h13}, '{1'h1, 1'h0, 8'h00, 8'h02, 8'h00, 8'h15},
    '{1'h0, 1'h1, 8'hfe, 8'h03, 8'h30, 8'h01}, '{1'h1, 1'h1, 8'hfe, 8'h03, 8'h00, 8'h01},
    '{1'h0, 1'h1, 8'h20, 8'h01, 8'hc5, 8'h21}, '{1'h1, 1'h0, 8'h00, 8'h01, 8'h00, 8'h22}};
  rtcp_bus_if u_rtcp_bus_if ();
  rtcp_bus_if u_rtcp_bus_if_b ();
  // second bus: the bench is master, pulling low through the enables
  assign u_rtcp_bus_if_b.scl_oe_m = b_scl;
  assign u_rtcp_bus_if_b.sda_oe_m = b_sda;
  assign u_rtcp_bus_if_b.scl_o_m = 1'h0;
  assign u_rtcp_bus_if_b.sda_o_m = 1'h0;
  assign rd_data = mem[reg_addr];
  assign wdata = wb + wi;
  rtcp_mst u_rtcp_mst (.core_clk(core_clk), .rst(rst), .bus(u_rtcp_bus_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_use_ptr(cmd_use_ptr), .cmd_ptr(cmd_ptr), .cmd_len(cmd_len), .wdata(wdata),
    .wdata_take(wdata_take), .rdata(rdata), .rdata_valid(rdata_valid), .nack_err(nack_err));
  rtcp_dev u_rtcp_dev (.core_clk(core_clk), .rst(rst), .bus(u_rtcp_bus_if),
    .reg_addr(reg_addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_data(rd_data), .busy(busy));
  rtcp_dev u_rtcp_dev_b (.core_clk(core_clk), .rst(rst), .bus(u_rtcp_bus_if_b),
    .reg_addr(reg_addr_b), .wr_data(), .wr_stb(), .rd_data(8'h00), .busy(busy_b));
  rtcp_props u_rtcp_props (.core_clk(core_clk), .rst(rst), .scl(u_rtcp_bus_if.scl),
    .sda(u_rtcp_bus_if.sda), .sda_oe_s(u_rtcp_bus_if.sda_oe_s),
    .sda_oe_m(u_rtcp_bus_if.sda_oe_m));
  // clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input rtcp_byte_t e, input rtcp_byte_t s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic test_done;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  // register file behind the device, and data checks
  always @(posedge core_clk) begin
    if (wdata_take === 1'h1) wi <= #1 wi + 8'h01;
    if (wr_stb === 1'h1) begin
      chk("wr_addr", exp_p + cnt, reg_addr);
      chk("wr_data", wb + cnt, wr_data);
      mem[reg_addr] <= wr_data;
      cnt <= cnt + 8'h01;
    end
    if (rdata_valid === 1'h1) begin
      chk("rdata", exp_mem[exp_p + cnt], rdata);
      cnt <= cnt + 8'h01;
    end
  end
  // one command to the master, then wait for it to go idle
  task automatic run_row(input rtcp_row_s r);
    int n = 0;
    exp_p = r.up ? r.ptr : cur_p;
    wb = r.wb;
    wi = 8'h00;
    cnt = 8'h00;
    cmd_read = r.rd;
    cmd_use_ptr = r.up;
    cmd_ptr = r.ptr;
    cmd_len = r.len;
    cmd_valid = 1'h1;
    @(posedge core_clk);
    #1 cmd_valid = 1'h0;
    while (cmd_ready !== 1'h1 && n < 5000) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk("done", 8'h01, {7'h00, cmd_ready});
    chk("busy_end", 8'h00, {7'h00, busy});
    chk("count", r.len, cnt);
    chk("pointer", r.endp, reg_addr);
    chk("nack", 8'h00, {7'h00, nack_err});
    for (int i = 0; i < r.len; i++) begin
      if (!r.rd) exp_mem[r.ptr + i[7:0]] = r.wb + i[7:0];
    end
    cur_p = r.endp;
  endtask : run_row
  // quarter of the 320 ns bit clock on the second bus
  task automatic qtr;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : qtr
  // start or repeated start on the second bus
  task automatic bb_go;
    b_sda = 1'h0;
    qtr();
    b_scl = 1'h0;
    qtr();
    b_sda = 1'h1;
    qtr();
    b_scl = 1'h1;
    qtr();
  endtask : bb_go
  // eight bits msb first, then the acknowledge slot
  task automatic bb_byte(input rtcp_byte_t b, output logic a);
    for (int i = 7; i >= -1; i--) begin
      b_sda = (i >= 0) ? !b[i[2:0]] : 1'h0;
      qtr();
      b_scl = 1'h0;
      qtr();
      a = !u_rtcp_bus_if_b.sda;
      qtr();
      b_scl = 1'h1;
      qtr();
    end
  endtask : bb_byte
  // stop on the second bus, then time for the device to see it
  task automatic bb_stop;
    b_sda = 1'h1;
    qtr();
    b_scl = 1'h0;
    qtr();
    b_sda = 1'h0;
    qtr();
    qtr();
  endtask : bb_stop
  // main sequence
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
      exp_mem[i] = i[7:0] ^ 8'h5a;
    end
    repeat (5) @(posedge core_clk);
    #1 rst = 1'h0;
    chk("rst_ptr", 8'h00, reg_addr);
    chk("rst_bus", 8'h03, {6'h00, u_rtcp_bus_if.scl, u_rtcp_bus_if.sda});
    chk("rst_busy", 8'h00, {7'h00, busy});
    foreach (rows[i]) run_row(rows[i]);
    bb_go();
    bb_byte(8'hd2, ack);
    chk("ack_other", 8'h00, {7'h00, ack});
    bb_byte(8'h55, ack);
    chk("ack_data", 8'h00, {7'h00, ack});
    bb_go();
    bb_byte(8'hd0, ack);
    chk("ack_own", 8'h01, {7'h00, ack});
    bb_byte(8'h33, ack);
    chk("ack_ptr", 8'h01, {7'h00, ack});
    chk("ptr_own", 8'h33, reg_addr_b);
    chk("busy_open", 8'h01, {7'h00, busy_b});
    bb_stop();
    chk("busy_stop", 8'h00, {7'h00, busy_b});
    // reset in mid transaction on the second bus
    bb_go();
    bb_byte(8'hd0, ack);
    chk("ack_again", 8'h01, {7'h00, ack});
    rst = 1'h1;
    repeat (5) @(posedge core_clk);
    #1 rst = 1'h0;
    chk("rst_busy_b", 8'h00, {7'h00, busy_b});
    chk("rst_ptr_b", 8'h00, reg_addr_b);
    chk("rst_ptr_a", 8'h00, reg_addr);
    bb_stop();
    test_done();
  end
endmodule : rtcp_i2c_slave_port_tb
